/* File: core/lwc_lin_wake_ctrl.sv */
`timescale 1ns/10ps
module lwc_lin_wake_ctrl
  import lwc_pkg::*;
#(
  parameter int LIN_WAKE_CYCLES   = LIN_WAKE_CYC,
  parameter int TX_TIMEOUT_CYCLES = TX_TIMEOUT_CYC,
  parameter int WAKE_FILT_CYCLES  = WAKE_FILT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire lwc_op_e     op_mode,
  input  wire logic        mid_below_por_low,
  input  wire logic        mid_above_por_high,
  input  wire logic        battery_low_threshold,
  input  wire logic [1:0]  lin_bus_pin,
  input  wire logic [1:0]  lin_tx_input,
  input  wire logic        local_wake_pin,
  input  wire logic        dev_mode_strap_pin,
  input  wire logic        failsafe_strap_pin,
  input  wire logic        wd_failure,
  input  wire logic        reset_out_n_clamped,
  output logic [1:0]       lin_rx_output,
  output logic [1:0]       lin_tx_dominant,
  output logic             lin_low_slope,
  output logic             wake_pull_up,
  output logic             wake_pull_down,
  output logic             wake_irq_req,
  output logic             wake_reset_req,
  output logic             reset_out_n,
  output logic             main_supply_uv_n,
  output logic             supply_enable,
  output logic             sdo_enable,
  output logic             powerup_start,
  output logic             failsafe_outputs,
  output logic             failsafe_mode_req
);

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] flt;
    lwc_top_e        fsm;
    lwc_ctrl_s       ctrl;
    lwc_strap_s      strap;
    logic            wu_flag;
    logic [1:0]      lin_flag;
    logic            wd_flag;
    logic [1:0]      fails;
    logic            fso;
    logic            fs_req;
    logic            irq;
    logic            rst_req;
    logic            run;
    logic            pup;
    logic            slope;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } lwc_state_s;

  lwc_state_s st, next_st;

  logic          arst_n;
  lwc_lin_mode_e mode0, mode1;
  logic [1:0]    rx, txd, tout, lwk, lwp;
  logic          wu_level, wu_edge;

  // Falling below the low level drops straight into shut-down, no clock needed
  assign arst_n = presetn && !mid_below_por_low;

  // Sync filter: a change counts once stages two and three agree
  function automatic logic [NPIN-1:0] agree(logic [NPIN-1:0] a, logic [NPIN-1:0] b,
                                            logic [NPIN-1:0] old);
    agree = (~(a ^ b) & b) | ((a ^ b) & old);
  endfunction

  // Chip mode as seen by the channels; outside run everything is off
  function automatic lwc_op_e eff_op(lwc_top_e fsm, lwc_op_e op);
    eff_op = (fsm == ST_RUN) ? op : OP_PWRUP_RESET;
  endfunction

  function automatic logic active_op(lwc_op_e op);
    active_op = op inside {OP_STARTUP, OP_NORMAL, OP_STANDBY, OP_FLASH};
  endfunction

  assign mode0 = lin_mode(st.ctrl.lin0_field, eff_op(st.fsm, op_mode));
  assign mode1 = lin_mode(st.ctrl.lin1_field, eff_op(st.fsm, op_mode));

  // Two identical transceiver channels
  for (genvar i = 0; i < 2; i++)
  begin : g_lin
    lwc_lin_chan #(
      .WAKE_CYC (LIN_WAKE_CYCLES),
      .TO_CYC   (TX_TIMEOUT_CYCLES)
    ) u_chan (
      .pclk       (pclk),
      .arst_n     (arst_n),
      .mode       (i == 0 ? mode0 : mode1),
      .tx_in      (st.flt[PIN_TX + i]),
      .bus_in     (st.flt[PIN_BUS + i]),
      .to_dis     (st.ctrl.to_dis),
      .bat_low    (st.flt[PIN_BAT]),
      .rx_out     (rx[i]),
      .tx_dom     (txd[i]),
      .timed_out  (tout[i]),
      .waked      (lwk[i]),
      .wake_pulse (lwp[i])
    );
  end

  lwc_wake_filt #(
    .FILT_CYC (WAKE_FILT_CYCLES)
  ) u_wake (
    .pclk       (pclk),
    .arst_n     (arst_n),
    .pin        (st.flt[PIN_WU]),
    .edge_sel   (st.ctrl.wake_edge_select),
    .level      (wu_level),
    .pull_up    (wake_pull_up),
    .pull_down  (wake_pull_down),
    .edge_pulse (wu_edge)
  );

  always_comb
  begin
    logic        setup, wr;
    logic [31:0] stat;
    logic [31:0] rd;
    logic        wake_ev, sampled_cfg, act;
    setup       = 1'b0;
    wr          = 1'b0;
    stat        = 32'h0000_0000;
    rd          = 32'h0000_0000;
    wake_ev     = 1'b0;
    sampled_cfg = 1'b0;
    act         = 1'b0;
    next_st = st;
    // Pin synchronisers
    next_st.s1  = {failsafe_strap_pin, dev_mode_strap_pin, local_wake_pin, lin_tx_input,
                   lin_bus_pin, battery_low_threshold, mid_above_por_high};
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    next_st.flt = agree(st.s2, st.s3, st.flt);

    // Status word
    stat[ST_BAT_LOW]  = st.flt[PIN_BAT];
    stat[ST_WU_LEVEL] = active_op(op_mode) && st.fsm == ST_RUN && wu_level;
    stat[ST_WU_FLAG]  = st.wu_flag;
    stat[ST_LIN0_WK]  = st.lin_flag[0];
    stat[ST_LIN1_WK]  = st.lin_flag[1];
    stat[ST_DEV_MODE] = st.strap.dev_mode;
    stat[ST_CFG_PIN]  = st.strap.dev_mode ? st.flt[PIN_CFG] : st.strap.cfg;
    stat[ST_WD_FAIL]  = st.wd_flag;
    stat[ST_TX0_TO]   = tout[0];
    stat[ST_TX1_TO]   = tout[1];

    // APB: one wait-free access phase, answer registered at setup
    setup = psel && !penable;
    wr    = psel && penable && st.pready && pwrite;
    next_st.pready = setup;
    if (setup)
    begin
      unique case (paddr)
        ADDR_CTRL:   rd = {23'h000000, st.ctrl};
        ADDR_STATUS: rd = stat;
        ADDR_CLEAR:  rd = 32'h0000_0000;
        ADDR_CMD:    rd = 32'h0000_0000;
        default:     rd = 32'h0000_0000;
      endcase
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd;
      next_st.pslverr = !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_CLEAR, ADDR_CMD}) ||
                        (!pwrite && paddr == ADDR_CLEAR) || (!pwrite && paddr == ADDR_CMD);
    end
    else
    begin
      // Answer stands in the access phase only, zero otherwise
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
    end
    // Control writes only while the serial side is alive
    if (wr && paddr == ADDR_CTRL && st.fsm == ST_RUN)
      next_st.ctrl = lwc_ctrl_s'(pwdata[8:0]);
    // Write-one-to-clear, a same-cycle event still sets the flag
    if (wr && paddr == ADDR_CLEAR)
    begin
      next_st.wu_flag  = st.wu_flag && !pwdata[ST_WU_FLAG];
      next_st.lin_flag = st.lin_flag & ~pwdata[ST_LIN1_WK:ST_LIN0_WK];
      next_st.wd_flag  = st.wd_flag && !pwdata[ST_WD_FAIL];
    end

    // Wake events; none are seen outside run
    next_st.irq     = 1'b0;
    next_st.rst_req = 1'b0;
    if (st.fsm == ST_RUN && op_mode != OP_PWRUP_RESET)
    begin
      if (wu_edge)
        next_st.wu_flag = 1'b1;
      next_st.lin_flag = next_st.lin_flag | lwp;
      wake_ev = wu_edge || (|lwp);
      next_st.irq     = wake_ev && active_op(op_mode);
      next_st.rst_req = wake_ev && !active_op(op_mode);
    end

    // Watchdog failure and clamped reset reaction
    next_st.fs_req = 1'b0;
    if (st.fsm == ST_RUN && wd_failure)
    begin
      next_st.wd_flag = 1'b1;
      if (!st.strap.dev_mode)
      begin
        act = st.ctrl.fast_fs ? (st.fails == 2'h0) : (st.fails == 2'h1);
        if (st.fails != 2'h3)
          next_st.fails = st.fails + 2'h1;
        if (act && (st.strap.cfg || !st.ctrl.fast_fs))
          next_st.fso = 1'b1;
        if (act && !st.strap.cfg)
          next_st.fs_req = 1'b1;
      end
    end
    // Development configuration never acts on a clamped reset
    if (st.fsm == ST_RUN && reset_out_n_clamped && !st.strap.dev_mode)
    begin
      next_st.fso = 1'b1;
      if (!st.strap.cfg)
        next_st.fs_req = 1'b1;
    end

    // Shut-down and configuration sequencing
    next_st.pup = 1'b0;
    unique case (st.fsm)
      ST_SHUTDOWN:
        if (st.flt[PIN_PORH])
          next_st.fsm = ST_CONFIG;
      ST_CONFIG:
      begin
        // Straps are caught here only, so later pin changes cannot alter them
        next_st.strap = '{dev_mode: st.flt[PIN_DEV], cfg: st.flt[PIN_CFG]};
        next_st.fails = 2'h0;
        next_st.fso   = 1'b0;
        next_st.fsm   = ST_RUN;
        next_st.pup   = 1'b1;
      end
      ST_RUN:
        if (wr && paddr == ADDR_CMD && pwdata[CMD_CONFIG] &&
            op_mode inside {OP_STARTUP, OP_NORMAL})
          next_st.fsm = ST_CONFIG;
      default:
        next_st.fsm = ST_SHUTDOWN;
    endcase
    sampled_cfg = next_st.strap.cfg;
    // Supplies, resets and serial output held off outside run
    next_st.run   = (next_st.fsm == ST_RUN) && sampled_cfg == next_st.strap.cfg;
    next_st.slope = next_st.ctrl.low_slope;
  end

  // Single state register, shut-down is the reset state
  always_ff @(posedge pclk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{s1: '0, s2: '0, s3: '0, flt: '0, fsm: ST_SHUTDOWN, ctrl: CTRL_RST,
              strap: '0, wu_flag: 1'b0, lin_flag: 2'h0, wd_flag: 1'b0, fails: 2'h0,
              fso: 1'b0, fs_req: 1'b0, irq: 1'b0, rst_req: 1'b0, run: 1'b0, pup: 1'b0,
              slope: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    else
      st <= next_st;
  end

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign lin_rx_output     = rx;
  assign lin_tx_dominant   = txd;
  assign lin_low_slope     = st.slope;
  assign wake_irq_req      = st.irq;
  assign wake_reset_req    = st.rst_req;
  assign reset_out_n       = st.run;
  assign main_supply_uv_n  = st.run;
  assign supply_enable     = st.run;
  assign sdo_enable        = st.run;
  assign powerup_start     = st.pup;
  assign failsafe_outputs  = st.fso;
  assign failsafe_mode_req = st.fs_req;

endmodule

/* File: core/lwc_pkg.sv */
package lwc_pkg;

  // Clock and time figures
  localparam int CLK_PERIOD_NS   = 20;
  localparam int WAKE_FILT_NS    = 50_000;
  localparam int LIN_WAKE_NS     = 100_000;
  localparam int TX_TIMEOUT_NS   = 20_000_000;
  // Least times round up to whole cycles
  localparam int WAKE_FILT_CYC   = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LIN_WAKE_CYC    = (LIN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_TIMEOUT_CYC  = (TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CLEAR  = 12'h008;
  localparam logic [11:0] ADDR_CMD    = 12'h00c;

  // Status and clear bit positions
  localparam int ST_BAT_LOW  = 0;
  localparam int ST_WU_LEVEL = 1;
  localparam int ST_WU_FLAG  = 2;
  localparam int ST_LIN0_WK  = 3;
  localparam int ST_LIN1_WK  = 4;
  localparam int ST_DEV_MODE = 5;
  localparam int ST_CFG_PIN  = 6;
  localparam int ST_WD_FAIL  = 7;
  localparam int ST_TX0_TO   = 8;
  localparam int ST_TX1_TO   = 9;
  localparam int CMD_CONFIG  = 0;

  // Sync vector bit positions
  localparam int PIN_PORH = 0;
  localparam int PIN_BAT  = 1;
  localparam int PIN_BUS  = 2;
  localparam int PIN_TX   = 4;
  localparam int PIN_WU   = 6;
  localparam int PIN_DEV  = 7;
  localparam int PIN_CFG  = 8;
  localparam int NPIN     = 9;

  typedef enum logic [2:0] {
    OP_PWRUP_RESET, OP_STARTUP, OP_NORMAL, OP_FLASH, OP_STANDBY, OP_SLEEP, OP_FAILSAFE
  } lwc_op_e;
  typedef enum logic [1:0] {LIN_OFF, LIN_WAKE, LIN_RXO, LIN_NORM} lwc_lin_mode_e;
  typedef enum logic [1:0] {ST_SHUTDOWN, ST_CONFIG, ST_RUN} lwc_top_e;

  typedef struct packed {
    logic       fast_fs;
    logic [1:0] wake_edge_select;
    logic       low_slope;
    logic       to_dis;
    logic [1:0] lin1_field;
    logic [1:0] lin0_field;
  } lwc_ctrl_s;
  localparam lwc_ctrl_s CTRL_RST = 9'h000;

  typedef struct packed {
    logic dev_mode;
    logic cfg;
  } lwc_strap_s;

  // Channel mode from control field and chip mode
  function automatic lwc_lin_mode_e lin_mode(logic [1:0] field, lwc_op_e op);
    if (op == OP_FAILSAFE)
      lin_mode = LIN_WAKE;
    else if (op == OP_PWRUP_RESET)
      lin_mode = LIN_OFF;
    else if (op == OP_SLEEP && field != 2'h1)
      lin_mode = LIN_OFF;
    else
      lin_mode = lwc_lin_mode_e'(field);
  endfunction

endpackage

/* File: core/lwc_lin_chan.sv */
`timescale 1ns/10ps
module lwc_lin_chan
  import lwc_pkg::*;
#(
  parameter int WAKE_CYC = LIN_WAKE_CYC,
  parameter int TO_CYC   = TX_TIMEOUT_CYC
) (
  input  wire logic          pclk,
  input  wire logic          arst_n,
  input  wire lwc_lin_mode_e mode,
  input  wire logic          tx_in,
  input  wire logic          bus_in,
  input  wire logic          to_dis,
  input  wire logic          bat_low,
  output logic               rx_out,
  output logic               tx_dom,
  output logic               timed_out,
  output logic               waked,
  output logic               wake_pulse
);
  localparam int WW = $clog2(WAKE_CYC + 1);
  localparam int TW = $clog2(TO_CYC + 1);

  typedef struct packed {
    logic [WW-1:0] dom_cnt;
    logic [TW-1:0] to_cnt;
    logic          timed_out;
    logic          waked;
    logic          wp;
    logic          rx;
    logic          txd;
  } lwc_chan_s;

  lwc_chan_s st, next_st;

  always_comb
  begin
    next_st = st;
    next_st.wp = 1'b0;
    // Wake needs a long dominant then a recessive; stuck-low bus never wakes
    if (mode == LIN_WAKE)
    begin
      if (!bus_in)
      begin
        if (st.dom_cnt < WW'(WAKE_CYC))
          next_st.dom_cnt = st.dom_cnt + 1'b1;
      end
      else
      begin
        if (st.dom_cnt >= WW'(WAKE_CYC) && !st.waked)
        begin
          next_st.waked = 1'b1;
          next_st.wp    = 1'b1;
        end
        next_st.dom_cnt = '0;
      end
    end
    else
    begin
      next_st.waked   = 1'b0;
      next_st.dom_cnt = '0;
    end
    // Dominant time-out, battery level does not affect it
    if (mode != LIN_NORM || tx_in || to_dis)
    begin
      next_st.to_cnt    = '0;
      next_st.timed_out = 1'b0;
    end
    else if (st.to_cnt < TW'(TO_CYC))
      next_st.to_cnt = st.to_cnt + 1'b1;
    else
      next_st.timed_out = 1'b1;
    // Transmit only in normal mode, not timed out, battery fine
    next_st.txd = (mode == LIN_NORM) && !tx_in && !next_st.timed_out && !bat_low;
    // Receive path per mode
    unique case (mode)
      LIN_OFF:  next_st.rx = 1'b1;
      LIN_WAKE: next_st.rx = !next_st.waked;
      LIN_RXO:  next_st.rx = bus_in;
      LIN_NORM: next_st.rx = bus_in;
    endcase
  end

  always_ff @(posedge pclk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{dom_cnt: '0, to_cnt: '0, timed_out: 1'b0, waked: 1'b0, wp: 1'b0,
              rx: 1'b1, txd: 1'b0};
    else
      st <= next_st;
  end

  assign rx_out     = st.rx;
  assign tx_dom     = st.txd;
  assign timed_out  = st.timed_out;
  assign waked      = st.waked;
  assign wake_pulse = st.wp;
endmodule

/* File: core/lwc_wake_filt.sv */
`timescale 1ns/10ps
module lwc_wake_filt
  import lwc_pkg::*;
#(
  parameter int FILT_CYC = WAKE_FILT_CYC
) (
  input  wire logic       pclk,
  input  wire logic       arst_n,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            level,
  output logic            pull_up,
  output logic            pull_down,
  output logic            edge_pulse
);
  localparam int CW = $clog2(FILT_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          prev;
    logic          known;
    logic          level;
    logic          ep;
    logic          pu;
    logic          pd;
  } lwc_wf_s;

  lwc_wf_s st, next_st;

  // Level accepted only after it held for the filter time
  always_comb
  begin
    next_st = st;
    next_st.ep   = 1'b0;
    next_st.prev = pin;
    if (pin != st.prev)
      next_st.cnt = '0;
    else if (pin != st.level || !st.known)
    begin
      if (st.cnt < CW'(FILT_CYC))
        next_st.cnt = st.cnt + 1'b1;
      else
      begin
        next_st.level = pin;
        next_st.known = 1'b1;
        next_st.cnt   = '0;
        // Edges only from the filtered level, so short glitches are dropped
        if (st.known)
          next_st.ep = pin ? edge_sel[0] : edge_sel[1];
      end
    end
    else
      next_st.cnt = '0;
    // Pulls registered so the pins come straight from flops
    next_st.pu = next_st.known && next_st.level;
    next_st.pd = next_st.known && !next_st.level;
  end

  always_ff @(posedge pclk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{cnt: '0, prev: 1'b0, known: 1'b0, level: 1'b0, ep: 1'b0, pu: 1'b0, pd: 1'b0};
    else
      st <= next_st;
  end

  assign level      = st.level;
  assign pull_up    = st.pu;
  assign pull_down  = st.pd;
  assign edge_pulse = st.ep;
endmodule

/* File: test/lwc_props.sv */
`timescale 1ns/10ps
module lwc_props
  import lwc_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       mid_below_por_low,
  input wire logic       battery_low_threshold,
  input wire logic [1:0] lin_tx_dominant,
  input wire logic [1:0] lin_rx_output,
  input wire logic       reset_out_n,
  input wire logic       main_supply_uv_n,
  input wire logic       supply_enable,
  input wire logic       sdo_enable,
  input wire logic       powerup_start,
  input wire logic       wake_irq_req,
  input wire logic       wake_reset_req,
  input wire logic       wake_pull_up,
  input wire logic       wake_pull_down
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states: answer right after setup
  chk_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_err_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  chk_shut_outputs: assert property (!reset_out_n |-> !main_supply_uv_n && !sdo_enable)
    else $error("outputs active while held");
  chk_shut_rx_high: assert property (!supply_enable [*2] |-> lin_rx_output == 2'b11)
    else $error("rx low while supplies off");
  chk_shut_bus_idle: assert property (!supply_enable [*2] |-> lin_tx_dominant == 2'b00)
    else $error("bus driven while supplies off");
  chk_por_async: assert property (mid_below_por_low |-> !reset_out_n && !supply_enable)
    else $error("run outputs during undervoltage");
  chk_powerup_pulse: assert property (powerup_start |=> !powerup_start)
    else $error("power-up start not a pulse");
  // Sync delay is a few cycles, so judge after a long low-battery run
  chk_bat_blocks_tx: assert property (battery_low_threshold [*8] |-> lin_tx_dominant == 2'b00)
    else $error("transmit during low battery");
  chk_wake_excl: assert property (!(wake_irq_req && wake_reset_req))
    else $error("wake gives irq and reset");
  chk_pull_excl: assert property (!(wake_pull_up && wake_pull_down))
    else $error("both wake pulls on");
endmodule

/* File: test/lwc_partner.sv */
`timescale 1ns/10ps
module lwc_partner (
  input  wire logic [1:0] tx_want,
  input  wire logic [1:0] ext_dom,
  input  wire logic [1:0] lin_tx_dominant,
  output logic [1:0]      lin_tx_input,
  output logic [1:0]      lin_bus_pin
);
  // Protocol controller drives transmit data straight
  assign lin_tx_input = tx_want;
  // Pulled-up bus: any dominant driver wins
  assign lin_bus_pin = ~(lin_tx_dominant | ext_dom);
endmodule

/* File: test/lwc_lin_wake_ctrl_tb_top.sv */
`timescale 1ns/10ps
`define CHK(g,e) begin comparisons++; if ((g)!==(e)) begin error_cnt++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module lwc_lin_wake_ctrl_tb_top
  import lwc_pkg::*;
;
  logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, seed;
  lwc_op_e op_mode;
  logic mid_below_por_low, mid_above_por_high, battery_low_threshold, local_wake_pin;
  logic dev_mode_strap_pin, failsafe_strap_pin, wd_failure, lin_low_slope, wake_pull_up;
  logic wake_pull_down, wake_irq_req, wake_reset_req, reset_out_n, main_supply_uv_n;
  logic supply_enable, sdo_enable, powerup_start, failsafe_outputs, failsafe_mode_req, reset_out_n_clamped;
  logic [1:0] lin_bus_pin, lin_tx_input, lin_rx_output, lin_tx_dominant, txw, ext;
  logic [32:0] eq[$], mq[$];
  int error_cnt = 0, comparisons = 0, cyc = 0, irq_cnt = 0, rreq_cnt = 0, pu_cnt = 0;
  always #10 pclk = ~pclk;
  lwc_lin_wake_ctrl #(.LIN_WAKE_CYCLES(8), .TX_TIMEOUT_CYCLES(20), .WAKE_FILT_CYCLES(6)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_mode(op_mode), .mid_below_por_low(mid_below_por_low),
    .mid_above_por_high(mid_above_por_high), .battery_low_threshold(battery_low_threshold),
    .lin_bus_pin(lin_bus_pin), .lin_tx_input(lin_tx_input), .local_wake_pin(local_wake_pin),
    .dev_mode_strap_pin(dev_mode_strap_pin), .failsafe_strap_pin(failsafe_strap_pin),
    .wd_failure(wd_failure), .reset_out_n_clamped(reset_out_n_clamped), .lin_rx_output(lin_rx_output),
    .lin_tx_dominant(lin_tx_dominant), .lin_low_slope(lin_low_slope),
    .wake_pull_up(wake_pull_up), .wake_pull_down(wake_pull_down),
    .wake_irq_req(wake_irq_req), .wake_reset_req(wake_reset_req), .reset_out_n(reset_out_n),
    .main_supply_uv_n(main_supply_uv_n), .supply_enable(supply_enable),
    .sdo_enable(sdo_enable), .powerup_start(powerup_start),
    .failsafe_outputs(failsafe_outputs), .failsafe_mode_req(failsafe_mode_req));
  lwc_partner u_far (.tx_want(txw), .ext_dom(ext), .lin_tx_dominant(lin_tx_dominant),
    .lin_tx_input(lin_tx_input), .lin_bus_pin(lin_bus_pin));
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; release only after the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(negedge pclk); while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    eq.push_back(e); mq.push_back(m);
    apb(0, a, 0);
  endtask
  // Watcher takes the oldest note when read data appears
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      `CHK({pslverr, prdata} & mq[0], eq[0] & mq[0])
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    irq_cnt += (wake_irq_req === 1'b1);
    rreq_cnt += (wake_reset_req === 1'b1);
    pu_cnt += (powerup_start === 1'b1);
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    seed = 32'h17fb9f1f; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; op_mode = OP_NORMAL; mid_below_por_low = 0; mid_above_por_high = 0;
    battery_low_threshold = 0; ext = 0; txw = 2'b11; local_wake_pin = 0;
    dev_mode_strap_pin = 0; failsafe_strap_pin = 1; wd_failure = 0; reset_out_n_clamped = 0;
    wt(6); presetn <= 1; wt(8);
    `CHK(reset_out_n, 1'b0)
    `CHK(wake_pull_down, 1'b1)
    mid_above_por_high <= 1; wt(8);
    `CHK(reset_out_n, 1'b1)
    `CHK(pu_cnt, 1)
    rd(ADDR_STATUS, 33'h040, 33'h060);
    dev_mode_strap_pin <= 1; failsafe_strap_pin <= 0; wt(8);
    rd(ADDR_STATUS, 33'h040, 33'h060);
    rd(12'h010, 33'h100000000, '1);
    v = $random(seed);
    wr(ADDR_CTRL, v); rd(ADDR_CTRL, {24'h0, v[8:0]}, '1);
    $display("setup test done");
    wr(ADDR_CTRL, 32'h0f); txw <= 2'b10; wt(12);
    `CHK(lin_tx_dominant, 2'b01)
    `CHK(lin_rx_output, 2'b10)
    wt(30);
    `CHK(lin_tx_dominant, 2'b00)
    `CHK(lin_rx_output, 2'b11)
    txw <= 2'b11; wt(8); txw <= 2'b00; wt(8);
    `CHK(lin_tx_dominant, 2'b11)
    wr(ADDR_CTRL, 32'h1f); wt(30);
    `CHK(lin_tx_dominant, 2'b11)
    battery_low_threshold <= 1; wt(8);
    `CHK(lin_tx_dominant, 2'b00)
    rd(ADDR_STATUS, 33'h1, 33'h1);
    battery_low_threshold <= 0; ext <= 2'b01; wr(ADDR_CTRL, 32'h20); wt(8);
    `CHK({lin_rx_output, lin_tx_dominant}, 4'hc)
    `CHK(lin_low_slope, 1'b1)
    $display("normal test done");
    ext <= 0; txw <= 2'b11; wr(ADDR_CTRL, 32'h05); wt(8);
    ext <= 2'b01; wt(4); ext <= 0; wt(8);
    `CHK(lin_rx_output, 2'b11)
    ext <= 2'b01; wt(20);
    `CHK(lin_rx_output, 2'b11)
    ext <= 0; wt(8);
    `CHK(lin_rx_output, 2'b10)
    `CHK(irq_cnt, 1)
    rd(ADDR_STATUS, 33'h08, 33'h18);
    wr(ADDR_CLEAR, 32'h08); rd(ADDR_STATUS, 33'h0, 33'h08);
    wr(ADDR_CTRL, 32'h0a); ext <= 2'b10; txw <= 0; wt(8);
    `CHK({lin_rx_output, lin_tx_dominant}, 4'h4)
    ext <= 0; txw <= 2'b11;
    $display("lin wake test done");
    wr(ADDR_CTRL, 32'h40); local_wake_pin <= 1; wt(3); local_wake_pin <= 0; wt(10);
    rd(ADDR_STATUS, 33'h0, 33'h04);
    local_wake_pin <= 1; wt(16);
    `CHK(wake_pull_up, 1'b1)
    `CHK(irq_cnt, 2)
    rd(ADDR_STATUS, 33'h6, 33'h6);
    op_mode <= OP_SLEEP; wr(ADDR_CTRL, 32'h80); local_wake_pin <= 0; wt(16);
    `CHK(rreq_cnt, 1)
    op_mode <= OP_NORMAL; wr(ADDR_CTRL, 32'hc0); local_wake_pin <= 1; wt(16);
    `CHK(irq_cnt, 3)
    $display("wake pin test done");
    wr(ADDR_CMD, 32'h1); wt(8);
    `CHK(pu_cnt, 2)
    rd(ADDR_STATUS, 33'h20, 33'h60);
    failsafe_strap_pin <= 1; wt(8);
    rd(ADDR_STATUS, 33'h60, 33'h60);
    wd_failure <= 1; reset_out_n_clamped <= 1; wt(1); wd_failure <= 0; reset_out_n_clamped <= 0; wt(4);
    `CHK({failsafe_outputs, failsafe_mode_req}, 2'b00)
    rd(ADDR_STATUS, 33'h80, 33'h80);
    $display("config test done");
    dev_mode_strap_pin <= 0; mid_below_por_low <= 1; wt(2);
    `CHK({reset_out_n, supply_enable, lin_rx_output}, 4'h3)
    mid_below_por_low <= 0; wt(10);
    `CHK(pu_cnt, 3)
    rd(ADDR_STATUS, 33'h40, 33'h60);
    wd_failure <= 1; wt(1); wd_failure <= 0; wt(4);
    `CHK(failsafe_outputs, 1'b0)
    wd_failure <= 1; wt(1); wd_failure <= 0; wt(4);
    `CHK({failsafe_outputs, failsafe_mode_req}, 2'b10)
    $display("supply test done");
    report_and_stop();
  end
endmodule
bind lwc_lin_wake_ctrl lwc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .mid_below_por_low(mid_below_por_low), .battery_low_threshold(battery_low_threshold),
  .lin_tx_dominant(lin_tx_dominant), .lin_rx_output(lin_rx_output),
  .reset_out_n(reset_out_n), .main_supply_uv_n(main_supply_uv_n),
  .supply_enable(supply_enable), .sdo_enable(sdo_enable), .powerup_start(powerup_start),
  .wake_irq_req(wake_irq_req), .wake_reset_req(wake_reset_req),
  .wake_pull_up(wake_pull_up), .wake_pull_down(wake_pull_down));
